// ---- rtl/mcpwm_defines.svh ----
/*
 * Register offsets, field positions, reset values and keys of the motor PWM
 * fault and write-lock block. Assumes inclusion by bare name from rtl/.
 */
`ifndef MCPWM_DEFINES_SVH
`define MCPWM_DEFINES_SVH
// Behaviour
// RULE_01: Three duty generators drive six outputs as three high/low pairs.
// RULE_02: In complementary mode the low output is the inverse of the high.
// RULE_03: Two fault inputs; either enabled and asserted forces outputs safe.
// RULE_04: Enabled fault input that owns its pin turns on a weak pull-down.
// RULE_05: During reset both fault pins stay owned by the PWM unit.
// RULE_06: Every reset enables both fault inputs in latched mode.
// RULE_07: Software clears both faults before enabling the PWM unit.
// RULE_08: Latched fault clears only after pin high and flag cleared by software.
// RULE_09: Outputs resume at the next period or half-period boundary.
// RULE_10: Output control and both fault control registers are write-protected.
// RULE_11: Config bit 6 defaults one; zero removes protection entirely.
// RULE_12: Unlock is key writes 0xabcd then 0x4321 back to back.
// RULE_13: Protected write must be the very next register access after keys.
// RULE_14: Each unlock permits exactly one protected write.
// RULE_15: Wrong, disordered or interrupted key sequence leaves registers locked.

// ==========================================
// Register byte offsets
`define OFS_TIMEBASE   12'h000
`define OFS_DUTY1      12'h004
`define OFS_DUTY2      12'h008
`define OFS_DUTY3      12'h00c
`define OFS_OUTCTL     12'h010
`define OFS_FLTACTL    12'h014
`define OFS_FLTBCTL    12'h018
`define OFS_KEY        12'h01c
`define OFS_CONFIG     12'h020
`define OFS_IRQ_STAT   12'h024
`define OFS_IRQ_MASK   12'h028
`define OFS_STATUS     12'h02c

// ==========================================
// Fields and values
`define LOCK_BIT       6
`define CONFIG_RST     32'h0000_0040
`define KEY_FIRST      16'habcd
`define KEY_SECOND     16'h4321
`define FLT_EN_BIT     0
`define FLT_LATCH_BIT  1
`define FLT_RST        32'h0000_0003
`define OUTCTL_RST     32'h0000_0000
`define IRQ_FLTA_BIT   0
`define IRQ_FLTB_BIT   1
`define IRQ_PERIOD_BIT 2
`define IRQ_STAT_RST   3'h3
`endif

// ---- rtl/mcpwm_fault_lock.sv ----
/*
 * Motor PWM with fault latch and key write-lock, APB slave.
 * Assumes fault pins are asynchronous and synchronised here; active low faults.
 */
`timescale 1ns/100ps
`include "mcpwm_defines.svh"
module mcpwm_fault_lock #(
	parameter int CNT_W = 16
) (
	// APB
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Fault pins, active low
	input  wire logic              fault_input_a,
	input  wire logic              fault_input_b,
	output logic                   fault_a_pulldown_en,
	output logic                   fault_b_pulldown_en,
	output logic                   fault_a_owned,
	output logic                   fault_b_owned,
	// Strap
	input  wire logic              write_protect_config_bit,
	// Outputs
	output mcpwm_pkg::pwm_pins_t   pwm_out,
	output logic [5:0]             pwm_oe,
	output logic                   irq
);
	import mcpwm_pkg::*;

	// Counter width must fit the period field; refused at elaboration
	if (CNT_W < 2 || CNT_W > 16) begin : g_bad_cnt_w
		$error("CNT_W out of range");
	end

	// ==========================================
	// Registers
	logic [31:0]      timebase_ff, outctl_ff, flta_ff, fltb_ff, config_ff, mask_ff;
	logic [CNT_W-1:0] duty_ff [3];
	logic [2:0]       stat_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic             strap_taken_ff;
	key_state_t       key_ff, nxt_key;
	logic             fa_s1_ff, fa_s2_ff, fb_s1_ff, fb_s2_ff;
	logic             flta_lat_ff, fltb_lat_ff, safe_ff;
	pwm_pins_t        pins_ff;

	wire acc     = psel && penable;
	wire wr      = acc && pwrite;
	wire mapped  = (paddr[1:0] == 2'b00) && (paddr <= `OFS_STATUS);
	wire is_prot = (paddr == `OFS_OUTCTL) || (paddr == `OFS_FLTACTL) || (paddr == `OFS_FLTBCTL);
	wire locked  = config_ff[`LOCK_BIT];
	wire prot_ok = !locked || (key_ff == KEY_OPEN);                  // [RULE_10] [RULE_11]
	wire prot_wr = wr && is_prot && prot_ok;

	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;

	// ==========================================
	// Key sequence; any other access cancels it
	always_comb begin
		nxt_key = key_ff;
		if (acc) begin
			if (wr && paddr == `OFS_KEY && pwdata[15:0] == `KEY_FIRST)
				nxt_key = KEY_HALF;                                          // [RULE_12]
			else if (wr && paddr == `OFS_KEY && pwdata[15:0] == `KEY_SECOND && key_ff == KEY_HALF)
				nxt_key = KEY_OPEN;                                          // [RULE_12]
			else
				nxt_key = KEY_IDLE;                                          // [RULE_13] [RULE_14] [RULE_15]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) key_ff <= KEY_IDLE;
		else          key_ff <= nxt_key;
	end

	// Strap caught once after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_ff      <= `CONFIG_RST;                                  // [RULE_11]
			strap_taken_ff <= 1'b0;
		end else if (!strap_taken_ff) begin
			config_ff[`LOCK_BIT] <= write_protect_config_bit;
			strap_taken_ff       <= 1'b1;
		end
	end

	// ==========================================
	// Plain and protected registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timebase_ff <= 32'h0;
			outctl_ff   <= `OUTCTL_RST;
			flta_ff     <= `FLT_RST;                                        // [RULE_06]
			fltb_ff     <= `FLT_RST;                                        // [RULE_06]
			mask_ff     <= 32'h0;
			for (int i = 0; i < 3; i++) duty_ff[i] <= '0;
		end else if (wr) begin
			case (paddr)
				`OFS_TIMEBASE: timebase_ff <= pwdata;
				`OFS_DUTY1:    duty_ff[0]  <= pwdata[CNT_W-1:0];
				`OFS_DUTY2:    duty_ff[1]  <= pwdata[CNT_W-1:0];
				`OFS_DUTY3:    duty_ff[2]  <= pwdata[CNT_W-1:0];
				`OFS_OUTCTL:   if (prot_wr) outctl_ff <= pwdata & 32'h0000_0777; // [RULE_10]
				`OFS_FLTACTL:  if (prot_wr) flta_ff <= pwdata & 32'h0000_0003;   // [RULE_10]
				`OFS_FLTBCTL:  if (prot_wr) fltb_ff <= pwdata & 32'h0000_0003;   // [RULE_10]
				`OFS_IRQ_MASK: mask_ff <= pwdata & 32'h0000_0007;
				default: ;
			endcase
		end
	end

	// ==========================================
	// Fault pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fa_s1_ff <= 1'b1;
			fa_s2_ff <= 1'b1;
			fb_s1_ff <= 1'b1;
			fb_s2_ff <= 1'b1;
		end else begin
			fa_s1_ff <= fault_input_a;
			fa_s2_ff <= fa_s1_ff;
			fb_s1_ff <= fault_input_b;
			fb_s2_ff <= fb_s1_ff;
		end
	end

	wire fa_act = flta_ff[`FLT_EN_BIT] && !fa_s2_ff;                     // [RULE_03]
	wire fb_act = fltb_ff[`FLT_EN_BIT] && !fb_s2_ff;                     // [RULE_03]

	// Time base counter, period from timebase register low bits
	wire [CNT_W-1:0] per  = timebase_ff[CNT_W-1:0];
	wire             run  = timebase_ff[31];
	wire             wrap = run && (cnt_ff >= per);
	wire             half = run && (cnt_ff == (per >> 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)  cnt_ff <= '0;
		else if (!run) cnt_ff <= '0;
		else if (wrap) cnt_ff <= '0;
		else           cnt_ff <= cnt_ff + 1'b1;
	end

	// ==========================================
	// Sticky status, set wins over write-one-to-clear
	wire [2:0] ev  = {wrap, fa_act, fb_act} & 3'b111;
	wire [2:0] evs = {ev[2], ev[0], ev[1]};
	wire       clr = wr && paddr == `OFS_IRQ_STAT;
	// Fault flags come up set, so the reset latch needs a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) stat_ff <= `IRQ_STAT_RST;                             // [RULE_08]
		else          stat_ff <= (stat_ff & ~(clr ? pwdata[2:0] : 3'b000)) | evs;
	end
	assign irq = |(stat_ff & mask_ff[2:0]);

	// Latch clears only with pin high and, in latched mode, flag cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flta_lat_ff <= 1'b1;                                            // [RULE_06]
			fltb_lat_ff <= 1'b1;
		end else begin
			if (fa_act) flta_lat_ff <= 1'b1;
			else if (!flta_ff[`FLT_LATCH_BIT] || !stat_ff[`IRQ_FLTA_BIT]) flta_lat_ff <= 1'b0; // [RULE_08]
			if (fb_act) fltb_lat_ff <= 1'b1;
			else if (!fltb_ff[`FLT_LATCH_BIT] || !stat_ff[`IRQ_FLTB_BIT]) fltb_lat_ff <= 1'b0; // [RULE_08]
		end
	end

	// Safe state released only at period or half-period boundary
	wire fault_now = (flta_lat_ff && flta_ff[`FLT_EN_BIT]) || (fltb_lat_ff && fltb_ff[`FLT_EN_BIT]) || fa_act || fb_act;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)              safe_ff <= 1'b1;
		else if (fault_now)        safe_ff <= 1'b1;                         // [RULE_03]
		else if (wrap || half)     safe_ff <= 1'b0;                         // [RULE_09]
	end

	// ==========================================
	// Duty generators and pair outputs
	generate
		for (genvar g = 0; g < 3; g++) begin : g_pair
			wire hi = run && (cnt_ff < duty_ff[g]);                          // [RULE_01]
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pins_ff.high[g] <= 1'b0;
					pins_ff.low[g]  <= 1'b0;
				end else if (safe_ff || fault_now) begin
					pins_ff.high[g] <= 1'b0;                                 // [RULE_03]
					pins_ff.low[g]  <= 1'b0;
				end else begin
					pins_ff.high[g] <= hi;
					pins_ff.low[g]  <= outctl_ff[8+g] ? hi : !hi;            // [RULE_02]
				end
			end
		end
	endgenerate
	assign pwm_out = pins_ff;
	assign pwm_oe  = {outctl_ff[6:4], outctl_ff[2:0]};

	// Fault pin ownership and pull-downs
	assign fault_a_owned       = !presetn || flta_ff[`FLT_EN_BIT];       // [RULE_05]
	assign fault_b_owned       = !presetn || fltb_ff[`FLT_EN_BIT];       // [RULE_05]
	assign fault_a_pulldown_en = fault_a_owned;                           // [RULE_04]
	assign fault_b_pulldown_en = fault_b_owned;                           // [RULE_04]

	// ==========================================
	// Read mux
	always_comb begin
		prdata = 32'h0;
		case (paddr)
			`OFS_TIMEBASE: prdata = timebase_ff;
			`OFS_DUTY1:    prdata = 32'(duty_ff[0]);
			`OFS_DUTY2:    prdata = 32'(duty_ff[1]);
			`OFS_DUTY3:    prdata = 32'(duty_ff[2]);
			`OFS_OUTCTL:   prdata = outctl_ff;
			`OFS_FLTACTL:  prdata = flta_ff;
			`OFS_FLTBCTL:  prdata = fltb_ff;
			`OFS_CONFIG:   prdata = config_ff;
			`OFS_IRQ_STAT: prdata = {29'h0, stat_ff};
			`OFS_IRQ_MASK: prdata = mask_ff;
			`OFS_STATUS:   prdata = {26'h0, key_ff, fltb_lat_ff, flta_lat_ff, safe_ff};
			default:       prdata = 32'h0;
		endcase
	end

	// ==========================================
	// Checks
	a_locked_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `OFS_OUTCTL && locked && key_ff != KEY_OPEN) |=> $stable(outctl_ff)) // [RULE_15]
		else $error("locked write changed output control");
	a_one_write: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && key_ff == KEY_OPEN) |=> key_ff != KEY_OPEN) // [RULE_14]
		else $error("unlock allowed a second access");
	a_fault_safe: assert property (@(posedge pclk) disable iff (!presetn)
		fault_now |=> (pins_ff.high == 3'b000 && safe_ff)) // [RULE_03]
		else $error("outputs not safe under fault");
	a_compl_low: assert property (@(posedge pclk) disable iff (!presetn)
		(!safe_ff && !fault_now && !outctl_ff[8]) |=> pins_ff.low[0] == !pins_ff.high[0]) // [RULE_02]
		else $error("low side not complement");
	a_resume_edge: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(safe_ff) |-> $past(wrap || half)) // [RULE_09]
		else $error("resume off boundary");
	a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(flta_lat_ff && flta_ff[`FLT_LATCH_BIT] && stat_ff[`IRQ_FLTA_BIT]) |=> flta_lat_ff) // [RULE_08]
		else $error("latch cleared with flag set");
	a_key_pair: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(key_ff == KEY_OPEN) |->
		$past(wr && paddr == `OFS_KEY && pwdata[15:0] == `KEY_SECOND && key_ff == KEY_HALF)) // [RULE_12]
		else $error("open without second key");
	a_pin_owned: assert property (@(posedge pclk) disable iff (!presetn)
		flta_ff[`FLT_EN_BIT] |-> (fault_a_owned && fault_a_pulldown_en)) // [RULE_04]
		else $error("enabled fault pin not owned");
endmodule : mcpwm_fault_lock

// ---- rtl/mcpwm_pkg.sv ----
/*
 * Types of the motor PWM fault and write-lock block.
 * Assumes the defines header is not needed for these types.
 */
package mcpwm_pkg;
	// ==========================================
	// Key recognition states
	typedef enum logic [2:0] {
		KEY_IDLE  = 3'b001,
		KEY_HALF  = 3'b010,
		KEY_OPEN  = 3'b100
	} key_state_t;

	// Six outputs as three pairs
	typedef struct packed {
		logic [2:0] high;
		logic [2:0] low;
	} pwm_pins_t;
endpackage : mcpwm_pkg

// ---- tb/fault_source_model.sv ----
/*
 * Behavioural fault circuitry on one active-low fault pin.
 * Assumes the bench commands when the circuit drives the pin and to what level.
 */
`timescale 1ns/100ps
module fault_source_model (
	// Control
	input  wire logic pclk,
	input  wire logic drive_en,
	input  wire logic drive_val,
	input  wire logic pulldown_en,
	// Pin
	output logic      pin
);
	logic last_ff;
	// Released pin sinks low through the weak pull-down, so a broken wire is a fault
	assign pin = drive_en ? drive_val : (pulldown_en ? 1'b0 : ~last_ff);
	// Remember the last level so a floating pin shows no stale value
	always_ff @(posedge pclk) begin
		last_ff <= pin;
	end
endmodule : fault_source_model

// ---- tb/motor_pwm_fault_and_write_lock_bench.sv ----
/*
 * Self-checking bench of the fault latch and key write-lock.
 * Assumes the APB slave answers with pready tied high.
 */
`timescale 1ns/100ps
`include "mcpwm_defines.svh"
module motor_pwm_fault_and_write_lock_bench;
	import mcpwm_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, strap;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic fa, fb, fa_pd, fb_pd, fa_own, fb_own, fa_en, fa_val;
	logic fb_val, err;
	logic [5:0] pwm_oe;
	pwm_pins_t pwm_out;
	int fail_count, checked;
	// ==========================================
	// Design and far side
	mcpwm_fault_lock u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fault_input_a(fa), .fault_input_b(fb), .fault_a_pulldown_en(fa_pd), .fault_b_pulldown_en(fb_pd),
		.fault_a_owned(fa_own), .fault_b_owned(fb_own), .write_protect_config_bit(strap),
		.pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
	fault_source_model u_fa (.pclk(pclk), .drive_en(fa_en), .drive_val(fa_val), .pulldown_en(fa_pd), .pin(fa));
	fault_source_model u_fb (.pclk(pclk), .drive_en(1'b1), .drive_val(fb_val), .pulldown_en(fb_pd), .pin(fb));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// ==========================================
	// Shared tasks
	task automatic finish_test;
		if (fail_count == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One APB transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		if (n >= 20) begin
			fail_count++;
			finish_test();
		end
	endtask : apb
	task automatic unlock_wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, `OFS_KEY, 32'h0000_abcd);
		apb(1, `OFS_KEY, 32'h0000_4321);
		apb(1, a, d);
	endtask : unlock_wr
	// Bounded wait for a pwm pattern on the pins
	task automatic wait_pwm(input logic [5:0] e, input logic [5:0] m, input string nm);
		int n;
		for (n = 0; n < 200 && (pwm_out & m) !== e; n++) @(posedge pclk);
		chk(nm, e, pwm_out & m);
	endtask : wait_pwm
	task automatic do_reset;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("owned_in_reset", 4'hf, {fa_own, fb_own, fa_pd, fb_pd});
		repeat (14) @(posedge pclk);
		presetn <= 1'b1;
	endtask : do_reset
	// ==========================================
	// Scenarios
	task automatic t_reset_vals;
		apb(0, `OFS_FLTACTL, 0); chk("flta_ctl", `FLT_RST, rd);
		apb(0, `OFS_FLTBCTL, 0); chk("fltb_ctl", `FLT_RST, rd);
		apb(0, `OFS_CONFIG, 0); chk("lock_bit", 1, rd[`LOCK_BIT]);
		apb(0, `OFS_STATUS, 0); chk("latched", 2'b11, rd[2:1]);
		chk("safe_pins", 0, pwm_out);
	endtask : t_reset_vals
	task automatic t_lock;
		apb(1, `OFS_OUTCTL, 32'h77); apb(0, `OFS_OUTCTL, 0); chk("no_key", 0, rd);
		apb(1, `OFS_KEY, 32'h4321); apb(1, `OFS_KEY, 32'habcd); apb(1, `OFS_OUTCTL, 32'h77);
		apb(0, `OFS_OUTCTL, 0); chk("key_swap", 0, rd);
		apb(1, `OFS_KEY, 32'habcd); apb(1, `OFS_KEY, 32'h4321); apb(0, `OFS_CONFIG, 0);
		apb(1, `OFS_OUTCTL, 32'h77); apb(0, `OFS_OUTCTL, 0); chk("key_gap", 0, rd);
		unlock_wr(`OFS_OUTCTL, 32'h77); apb(0, `OFS_OUTCTL, 0); chk("unlocked", 32'h77, rd);
		chk("oe", 6'h3f, pwm_oe);
		apb(1, `OFS_OUTCTL, 0); apb(0, `OFS_OUTCTL, 0); chk("one_write", 32'h77, rd);
		apb(0, 12'h0fc, 0); chk("unmapped_err", 1, err);
	endtask : t_lock
	task automatic t_fault;
		apb(1, `OFS_IRQ_MASK, 32'h3);
		apb(1, `OFS_IRQ_STAT, 32'h3);
		apb(0, `OFS_STATUS, 0); chk("cleared", 0, rd[2:1]);
		apb(1, `OFS_DUTY1, 32'h8);
		apb(1, `OFS_TIMEBASE, 32'h8000_000f);
		wait_pwm(6'h08, 6'h09, "resume");
		chk("irq_idle", 0, irq);
		fa_val <= 1'b0;
		wait_pwm(0, 6'h3f, "fault_safe");
		chk("irq_set", 1, irq);
		apb(1, `OFS_IRQ_STAT, 32'h1);
		apb(0, `OFS_STATUS, 0); chk("held_latch", 1, rd[1]);
		apb(1, `OFS_IRQ_MASK, 0);
		@(posedge pclk);
		chk("irq_masked", 0, irq);
		// Pin released but flag still set: latch must hold
		fa_val <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(0, `OFS_STATUS, 0);
		chk("latch_pin_high", 1, rd[1]);
		apb(1, `OFS_IRQ_STAT, 32'h1);
		apb(0, `OFS_STATUS, 0);
		chk("latch_clear_a", 0, rd[1]);
		wait_pwm(6'h08, 6'h09, "resume_a");
		// Second fault input alone forces the safe state
		fb_val <= 1'b0;
		wait_pwm(0, 6'h3f, "fault_b_safe");
		fb_val <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1, `OFS_IRQ_STAT, 32'h2);
		apb(0, `OFS_STATUS, 0);
		chk("latch_clear_b", 0, rd[2]);
		wait_pwm(6'h08, 6'h09, "resume_b");
	endtask : t_fault
	task automatic t_strap;
		strap <= 1'b0;
		do_reset();
		apb(1, `OFS_OUTCTL, 32'h5); apb(0, `OFS_OUTCTL, 0); chk("unprotected", 32'h5, rd);
	endtask : t_strap
	// ==========================================
	// Main sequence
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 0; pwdata = 0;
		strap = 1'b1; fa_en = 1'b1; fa_val = 1'b1; fail_count = 0; checked = 0;
		fb_val = 1'b1;
		do_reset();
		t_reset_vals();
		t_lock();
		t_fault();
		t_strap();
		finish_test();
	end
endmodule : motor_pwm_fault_and_write_lock_bench
